// File: vectored_priority_interrupt_acceptor.sv
// Top level: interrupt acceptance, status word and accept sequence
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Reset loads status word 06H: both service bits set, enable flag clear.
// - A maskable source is eligible only when its request is 1 and mask 0.
// - Accept maskable only with enable flag set; lower never preempts higher.
// - Start servicing 9 to 16 clocks after request; upper bound waived in RAM.
// - Best programmed level wins; ties go to fixed default order.
// - Level code 00 is highest through 11 lowest, from high and low bits.
// - Accept pushes status then PC, clears enable, loads vector, branches.
// - Accept writes level code minus one to service bits; code 0 gives 00.
// - Service bits 00 level 0/1, 01 level 2, 10 level 3, 11 idle.
// - With enable set admit levels up to service bits; none when clear.
// - Level 0 handler with enable set still admits further level 0.
// - Blocked requests stay pending and are taken once eligible.
// - After a return run one program instruction before next accept.
// - Soft trap pushes status then PC, clears enable, vectors via 7EH/7FH.
// - Soft trap is never blocked by enable, service bits or active handler.
// - Returns and status pop restore status word; status push saves it.
// - Status word has byte and bit access; enable/off instructions set/clear.
module vectored_priority_interrupt_acceptor #(
  parameter int N_SRC = 8,
  parameter logic [19:0] VEC_BASE = 20'h00004
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Peripheral request sources, index 0 has the best default priority
  input wire irq_accept_pkg::src_t i_src [N_SRC],
  // Instruction sequencer
  input wire logic i_instr_done,
  input wire irq_accept_pkg::cmd_t i_cmd,
  input wire logic i_ram_exec,
  // Status word and accept sequence
  output logic [7:0] o_status,
  output logic o_busy,
  output logic o_push_st,
  output logic [7:0] o_push_data,
  output logic o_push_pc,
  output logic o_vec_load,
  output logic [19:0] o_vec_addr,
  output logic o_ack,
  output logic [$clog2(N_SRC)-1:0] o_ack_idx
);
  import irq_accept_pkg::*;
  localparam int IW = $clog2(N_SRC);
  localparam int CW = $clog2(MAX_LAT_CYC + 1);
  localparam logic [CW-1:0] MIN_AGE = CW'(MIN_LAT_CYC - 1);
  localparam logic [CW-1:0] MAX_AGE = CW'(MAX_LAT_CYC - 1);

  if (N_SRC < 2 || N_SRC > 64) begin : g_chk
    $error("acceptor: N_SRC must be 2 to 64");
  end

  logic arb_valid;
  logic [IW-1:0] arb_idx;
  logic [1:0] arb_prio;
  logic [CW-1:0] wait_cnt;
  logic [CW-1:0] age;
  logic idle, restart, admit, take_irq, take_trap, st_push_instr;
  acc_state_t state_q, state_d;
  logic [7:0] status_q, status_d, push_data_q, push_data_d;
  logic hold_q, hold_d, trap_q, trap_d;
  logic busy_q, busy_d, push_st_q, push_st_d, push_pc_q, push_pc_d;
  logic vec_load_q, vec_load_d, ack_q, ack_d;
  logic [19:0] vec_addr_q, vec_addr_d;
  logic [IW-1:0] acc_idx_q, acc_idx_d, prev_idx_q, prev_idx_d;
  logic prev_valid_q, prev_valid_d;

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and request age

  irq_arbiter #(.N_SRC(N_SRC)) u_arb (
    .i_src(i_src),
    .o_valid(arb_valid),
    .o_idx(arb_idx),
    .o_prio(arb_prio)
  );

  // A new winner counts as a freshly arisen request
  assign restart = arb_valid && (!prev_valid_q || arb_idx != prev_idx_q);

  irq_wait_timer #(.CW(CW)) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(arb_valid && idle),
    .i_restart(restart),
    .o_count(wait_cnt)
  );

  assign age = (restart || !arb_valid || !idle) ? '0 : wait_cnt;
  assign idle = state_q == ST_IDLE;

  // admitted when enabled and code not above service bits
  assign admit = arb_valid && status_q[IRQ_EN_POS] && arb_prio <= level_of(status_q);

  // trap ignores enable flag and service level
  assign take_trap = idle && i_instr_done && i_cmd.op == OP_SOFT_TRAP;
  assign st_push_instr = idle && i_instr_done && i_cmd.op == OP_STATUS_PUSH;

  // normal take at a plain instruction boundary once old enough
  // forced take at the upper bound, not while a return still holds it off.
  // Boundaries carrying status or return operations never take, so a take
  // never races a status update in the same cycle.
  assign take_irq = idle && admit && !take_trap &&
    ((i_instr_done && i_cmd.op == OP_NONE && age >= MIN_AGE) ||
     (!i_instr_done && !hold_q && !i_ram_exec && age >= MAX_AGE));

  ////////////////////////////////////////////////////////////////////////////
  // Status word and return hold

  always_comb begin
    status_d = status_q;
    hold_d = hold_q;
    if (idle && i_instr_done) begin
      // hold set by a return, cleared by the next instruction
      hold_d = i_cmd.op == OP_RETURN_FROM_IRQ || i_cmd.op == OP_RETURN_FROM_TRAP;
      case (i_cmd.op)
        OP_ENABLE_IRQ: status_d[IRQ_EN_POS] = 1'b1;
        OP_IRQ_OFF: status_d[IRQ_EN_POS] = 1'b0;
        // restore from stack on returns and status pop
        OP_RETURN_FROM_IRQ, OP_RETURN_FROM_TRAP, OP_STATUS_POP,
        OP_STATUS_WRITE: status_d = i_cmd.data;
        OP_BIT_SET: status_d[i_cmd.bit_idx] = 1'b1;
        OP_BIT_CLR: status_d[i_cmd.bit_idx] = 1'b0;
        OP_SOFT_TRAP: status_d[IRQ_EN_POS] = 1'b0;
        default: ;
      endcase
    end
    if (take_irq) begin
      // accept clears enable, so nesting needs a fresh enable
      status_d[IRQ_EN_POS] = 1'b0;
      // code minus one into service bits, code zero keeps 00
      status_d[SL_HI_POS] = arb_prio > 2'h2;
      status_d[SL_LO_POS] = arb_prio == 2'h2;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q <= STATUS_RESET;
      hold_q <= 1'b0;
    end else begin
      status_q <= status_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accept sequence

  always_comb begin
    state_d = state_q;
    trap_d = trap_q;
    acc_idx_d = acc_idx_q;
    case (state_q)
      ST_IDLE: begin
        if (take_trap || take_irq) begin
          state_d = ST_PUSH_ST;
          trap_d = take_trap;
          acc_idx_d = arb_idx;
        end
      end
      ST_PUSH_ST: state_d = ST_PUSH_PC;
      ST_PUSH_PC: state_d = ST_VECTOR;
      ST_VECTOR: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    busy_d = state_d != ST_IDLE;
    // status word goes first, snapshot taken before the update
    push_st_d = (idle && (take_trap || take_irq)) || st_push_instr;
    push_data_d = push_st_d ? status_q : push_data_q;
    push_pc_d = state_q == ST_PUSH_ST;
    vec_load_d = state_q == ST_PUSH_PC;
    ack_d = vec_load_d && !trap_q;
    // fixed trap vector, otherwise one two-byte entry per source
    if (!vec_load_d) begin
      vec_addr_d = vec_addr_q;
    end else if (trap_q) begin
      vec_addr_d = TRAP_VEC_LO;
    end else begin
      vec_addr_d = VEC_BASE + (20'(acc_idx_q) << 1);
    end
    prev_valid_d = arb_valid;
    prev_idx_d = arb_idx;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      trap_q <= 1'b0;
      acc_idx_q <= '0;
      busy_q <= 1'b0;
      push_st_q <= 1'b0;
      push_data_q <= '0;
      push_pc_q <= 1'b0;
      vec_load_q <= 1'b0;
      ack_q <= 1'b0;
      vec_addr_q <= '0;
      prev_valid_q <= 1'b0;
      prev_idx_q <= '0;
    end else begin
      state_q <= state_d;
      trap_q <= trap_d;
      acc_idx_q <= acc_idx_d;
      busy_q <= busy_d;
      push_st_q <= push_st_d;
      push_data_q <= push_data_d;
      push_pc_q <= push_pc_d;
      vec_load_q <= vec_load_d;
      ack_q <= ack_d;
      vec_addr_q <= vec_addr_d;
      prev_valid_q <= prev_valid_d;
      prev_idx_q <= prev_idx_d;
    end
  end

  assign o_status = status_q;
  assign o_busy = busy_q;
  assign o_push_st = push_st_q;
  assign o_push_data = push_data_q;
  assign o_push_pc = push_pc_q;
  assign o_vec_load = vec_load_q;
  assign o_vec_addr = vec_addr_q;
  assign o_ack = ack_q;
  assign o_ack_idx = acc_idx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic first_q;
  logic [1:0] min_prio;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_comb begin
    min_prio = 2'h3;
    for (int i = 0; i < N_SRC; i++) begin
      if (is_eligible(i_src[i]) && prio_of(i_src[i]) < min_prio) begin
        min_prio = prio_of(i_src[i]);
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_accept;
    o_push_st ##1 o_push_pc ##1 o_vec_load;
  endsequence

  property p_reset_status;
    first_q |-> o_status == STATUS_RESET && !o_busy;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("bad status after reset");

  property p_eligible;
    take_irq |-> is_eligible(i_src[arb_idx]);
  endproperty
  a_eligible: assert property (p_eligible) else $error("took ineligible source");

  property p_needs_enable;
    take_irq |-> o_status[IRQ_EN_POS];
  endproperty
  a_needs_enable: assert property (p_needs_enable) else $error("took with enable clear");

  property p_min_latency;
    ($rose(arb_valid) && idle) |-> (!take_irq) [*8];
  endproperty
  a_min_latency: assert property (p_min_latency) else $error("taken too early");

  property p_max_latency;
    (admit && idle && !hold_q && !i_ram_exec && !i_instr_done && age == MAX_AGE)
      |-> take_irq;
  endproperty
  a_max_latency: assert property (p_max_latency) else $error("upper bound missed");

  property p_best_level;
    take_irq |-> arb_prio == min_prio;
  endproperty
  a_best_level: assert property (p_best_level) else $error("not best level");

  property p_accept_seq;
    take_irq |=> s_accept ##0 (o_ack && !o_status[IRQ_EN_POS]);
  endproperty
  a_accept_seq: assert property (p_accept_seq) else $error("bad accept sequence");

  property p_level_update;
    take_irq |=> level_of(o_status) ==
      ($past(arb_prio) == 2'h0 ? 2'h0 : $past(arb_prio) - 2'h1);
  endproperty
  a_level_update: assert property (p_level_update) else $error("bad service level");

  property p_admit_level;
    take_irq |-> arb_prio <= level_of(o_status);
  endproperty
  a_admit_level: assert property (p_admit_level) else $error("level not admitted");

  property p_trap;
    take_trap |=> s_accept ##0 (o_vec_addr == TRAP_VEC_LO && !o_ack);
  endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");

  property p_restore;
    (idle && i_instr_done && (i_cmd.op == OP_RETURN_FROM_IRQ ||
      i_cmd.op == OP_STATUS_POP)) |=> o_status == $past(i_cmd.data);
  endproperty
  a_restore: assert property (p_restore) else $error("status not restored");

  property p_return_hold;
    hold_q && !i_instr_done |-> !take_irq;
  endproperty
  a_return_hold: assert property (p_return_hold) else $error("taken right after return");
endmodule

// File: irq_accept_pkg.sv
// Constants, types and helper functions of the vectored interrupt acceptor
package irq_accept_pkg;
  // Status word layout and value after reset
  localparam logic [7:0] STATUS_RESET = 8'h06;
  localparam int IRQ_EN_POS = 7;
  localparam int SL_HI_POS = 2;
  localparam int SL_LO_POS = 1;
  // Fixed software trap vector words
  localparam logic [19:0] TRAP_VEC_LO = 20'h0007E;
  localparam logic [19:0] TRAP_VEC_HI = 20'h0007F;
  // Acceptance latency, in CPU clocks and in core cycles
  localparam int MIN_LAT_CLK = 9;
  localparam int MAX_LAT_CLK = 16;
  localparam int CYC_PER_CPU_CLK = 1;
  localparam int MIN_LAT_CYC = MIN_LAT_CLK * CYC_PER_CPU_CLK;
  localparam int MAX_LAT_CYC = MAX_LAT_CLK * CYC_PER_CPU_CLK;

  typedef enum logic [3:0] {
    OP_NONE, OP_ENABLE_IRQ, OP_IRQ_OFF, OP_SOFT_TRAP, OP_RETURN_FROM_IRQ,
    OP_RETURN_FROM_TRAP, OP_STATUS_PUSH, OP_STATUS_POP, OP_STATUS_WRITE,
    OP_BIT_SET, OP_BIT_CLR
  } op_t;

  typedef struct packed {
    logic request_flag;
    logic mask_flag;
    logic prio_bit_high;
    logic prio_bit_low;
  } src_t;

  typedef struct packed {
    op_t op;
    logic [7:0] data;
    logic [2:0] bit_idx;
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PUSH_ST = 2'h1,
    ST_PUSH_PC = 2'h3,
    ST_VECTOR = 2'h2
  } acc_state_t;

  // level code from the two bits
  function automatic logic [1:0] prio_of(input src_t s);
    return {s.prio_bit_high, s.prio_bit_low};
  endfunction

  function automatic logic is_eligible(input src_t s);
    return s.request_flag && !s.mask_flag;
  endfunction

  function automatic logic [1:0] level_of(input logic [7:0] st);
    return {st[SL_HI_POS], st[SL_LO_POS]};
  endfunction
endpackage

// File: irq_arbiter.sv
// Picks the eligible source with the best level, lowest index on ties
`timescale 1ns/1ps
module irq_arbiter #(
  parameter int N_SRC = 8
) (
  // Sources
  input wire irq_accept_pkg::src_t i_src [N_SRC],
  // Winner
  output logic o_valid,
  output logic [$clog2(N_SRC)-1:0] o_idx,
  output logic [1:0] o_prio
);
  import irq_accept_pkg::*;
  localparam int IW = $clog2(N_SRC);

  if (N_SRC < 2 || N_SRC > 64) begin : g_chk
    $error("irq_arbiter: N_SRC must be 2 to 64");
  end

  // scanning downward with <= lets the lowest index win a tie
  always_comb begin
    o_valid = 1'b0;
    o_idx = '0;
    o_prio = 2'h3;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (is_eligible(i_src[i]) && (!o_valid || prio_of(i_src[i]) <= o_prio)) begin
        o_valid = 1'b1;
        o_idx = IW'(i);
        o_prio = prio_of(i_src[i]);
      end
    end
  end
endmodule

// File: irq_wait_timer.sv
// Counts cycles since the current winning request appeared
`timescale 1ns/1ps
module irq_wait_timer #(
  parameter int CW = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire logic i_restart,
  // Age
  output logic [CW-1:0] o_count
);
  logic [CW-1:0] count_q, count_d;

  if (CW < 2 || CW > 16) begin : g_chk
    $error("irq_wait_timer: CW must be 2 to 16");
  end

  // Saturates so a long-blocked request keeps its full age
  always_comb begin
    if (!i_run) begin
      count_d = '0;
    end else if (i_restart) begin
      count_d = CW'(1);
    end else if (count_q == {CW{1'b1}}) begin
      count_d = count_q;
    end else begin
      count_d = count_q + CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;
endmodule

// File: irq_src_model.sv
// Peripheral request sources facing the interrupt acceptor
`timescale 1ns/1ps
module irq_src_model
  import irq_accept_pkg::*;
#(
  parameter int N_SRC = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Bench controls
  input wire logic [N_SRC-1:0] i_set,
  input wire logic [N_SRC-1:0] i_mask,
  input wire logic [2*N_SRC-1:0] i_prio,
  // Acknowledge from the device
  input wire logic i_ack,
  input wire logic [$clog2(N_SRC)-1:0] i_ack_idx,
  // Source flags
  output irq_accept_pkg::src_t o_src [N_SRC]
);
  import irq_accept_pkg::*;
  logic [N_SRC-1:0] req_q;
  logic [N_SRC-1:0] req_d;
  ////////////////////////////////////////////////////////////////////////////
  // The device never clears a flag, so the source drops it on acknowledge
  always_comb begin
    req_d = req_q | i_set;
    if (i_ack) begin
      req_d[i_ack_idx] = 1'b0;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // request, mask, level
  always_comb begin
    for (int i = 0; i < N_SRC; i++) begin
      o_src[i] = '{req_q[i] | i_set[i], i_mask[i], i_prio[2*i+1], i_prio[2*i]};
    end
  end
endmodule

// File: vectored_priority_interrupt_acceptor_tb.sv
// Self-checking bench for the vectored interrupt acceptor
`timescale 1ns/1ps
module vectored_priority_interrupt_acceptor_tb;
  import irq_accept_pkg::*;
  logic i_clk, i_sys_rst, i_instr_done, i_ram_exec;
  cmd_t i_cmd;
  src_t src [8];
  logic [7:0] set_v, mask_v, o_status, o_push_data;
  logic [15:0] prio_v;
  logic o_busy, o_push_st, o_push_pc, o_vec_load, o_ack;
  logic [19:0] o_vec_addr;
  logic [2:0] o_ack_idx;
  int miscompares, check_count, cycles;
  op_t tops [7] = '{OP_STATUS_PUSH, OP_STATUS_POP, OP_BIT_SET, OP_BIT_CLR, OP_IRQ_OFF,
                    OP_ENABLE_IRQ, OP_STATUS_WRITE};
  logic [7:0] tdat [7] = '{8'h00, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06};
  logic [2:0] tidx [7] = '{3'h0, 3'h0, 3'h7, 3'h3, 3'h0, 3'h0, 3'h0};
  logic [7:0] texp [7] = '{8'h06, 8'h5A, 8'hDA, 8'hD2, 8'h52, 8'hD2, 8'h06};
  ////////////////////////////////////////////////////////////////////////////
  vectored_priority_interrupt_acceptor vectored_priority_interrupt_acceptor_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_src(src), .i_instr_done(i_instr_done),
    .i_cmd(i_cmd), .i_ram_exec(i_ram_exec), .o_status(o_status), .o_busy(o_busy),
    .o_push_st(o_push_st), .o_push_data(o_push_data), .o_push_pc(o_push_pc),
    .o_vec_load(o_vec_load), .o_vec_addr(o_vec_addr), .o_ack(o_ack), .o_ack_idx(o_ack_idx));
  irq_src_model irq_src_model_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_set(set_v), .i_mask(mask_v), .i_prio(prio_v),
    .i_ack(o_ack), .i_ack_idx(o_ack_idx), .o_src(src));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Sequencer stalls while the accept sequence runs
  task automatic instr(input op_t op, input logic [7:0] dat, input logic [2:0] idx);
    while (o_busy) @(negedge i_clk);
    @(posedge i_clk);
    i_instr_done <= 1'b1;
    i_cmd <= '{op, dat, idx};
    @(posedge i_clk);
    i_instr_done <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic raise(input logic [7:0] m);
    @(posedge i_clk);
    set_v <= m;
    @(posedge i_clk);
    set_v <= 8'h00;
    @(negedge i_clk);
  endtask
  task automatic idle(input int k);
    logic b;
    b = 1'b0;
    repeat (k) begin
      @(negedge i_clk);
      b = b | o_busy;
    end
    check(b, 1'b0);
  endtask
  // Waits for the accept, optionally with plain boundaries, then walks it
  task automatic take(input logic [2:0] idx, input logic [7:0] old, input logic [7:0] nw,
                      input logic [19:0] vec, input logic ack, input logic bnd, input logic lat);
    int n;
    n = 1;
    while (o_busy !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      i_instr_done <= bnd && !i_instr_done;
      i_cmd <= '{OP_NONE, 8'h00, 3'h0};
      @(negedge i_clk);
      n++;
    end
    if (lat) check(n >= 9 && n <= 16, 1'b1);
    check(o_push_st, 1'b1);
    check(o_push_data, old);
    check(o_status, nw);
    @(posedge i_clk);
    i_instr_done <= 1'b0;
    @(negedge i_clk);
    check(o_push_pc, 1'b1);
    @(negedge i_clk);
    check(o_vec_load, 1'b1);
    check(o_vec_addr, vec);
    check(o_ack, ack);
    if (ack) check(o_ack_idx, idx);
    @(negedge i_clk);
    check(o_busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_rst = 1'b1;
    i_instr_done = 1'b0;
    i_cmd = '0;
    i_ram_exec = 1'b0;
    set_v = 8'h00;
    mask_v = 8'h01;
    prio_v = 16'h50F8;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    check(o_status, 8'h06);
    for (int i = 0; i < 7; i++) begin
      instr(tops[i], tdat[i], tidx[i]);
      check(o_status, texp[i]);
      check(o_push_st, tops[i] == OP_STATUS_PUSH);
      if (tops[i] == OP_STATUS_PUSH) check(o_push_data, 8'h06);
    end
    $display("test status_ops done");
    raise(8'h04);
    idle(30);
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    take(3'h2, 8'h86, 8'h04, 20'h00008, 1'b1, 1'b0, 1'b0);
    $display("test pending_enable done");
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    raise(8'h08);
    idle(25);
    raise(8'h02);
    take(3'h1, 8'h84, 8'h02, 20'h00006, 1'b1, 1'b0, 1'b1);
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    raise(8'h10);
    take(3'h4, 8'h82, 8'h00, 20'h0000C, 1'b1, 1'b1, 1'b1);
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    raise(8'h60);
    take(3'h5, 8'h80, 8'h00, 20'h0000E, 1'b1, 1'b0, 1'b0);
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    idle(20);
    $display("test nesting done");
    // maskable handlers leave by interrupt return
    instr(OP_RETURN_FROM_IRQ, 8'h86, 3'h0);
    check(o_status, 8'h86);
    idle(20);
    instr(OP_NONE, 8'h00, 3'h0);
    take(3'h6, 8'h86, 8'h00, 20'h00010, 1'b1, 1'b0, 1'b0);
    instr(OP_RETURN_FROM_IRQ, 8'h86, 3'h0);
    instr(OP_NONE, 8'h00, 3'h0);
    take(3'h3, 8'h86, 8'h04, 20'h0000A, 1'b1, 1'b0, 1'b0);
    $display("test return_hold done");
    instr(OP_STATUS_WRITE, 8'h06, 3'h0);
    raise(8'hC1);
    instr(OP_ENABLE_IRQ, 8'h00, 3'h0);
    take(3'h6, 8'h86, 8'h00, 20'h00010, 1'b1, 1'b0, 1'b0);
    instr(OP_RETURN_FROM_IRQ, 8'h86, 3'h0);
    instr(OP_NONE, 8'h00, 3'h0);
    take(3'h7, 8'h86, 8'h00, 20'h00012, 1'b1, 1'b0, 1'b0);
    instr(OP_RETURN_FROM_IRQ, 8'h86, 3'h0);
    instr(OP_NONE, 8'h00, 3'h0);
    idle(20);
    @(posedge i_clk);
    mask_v <= 8'h00;
    take(3'h0, 8'h86, 8'h00, 20'h00004, 1'b1, 1'b0, 1'b0);
    $display("test arbitration done");
    // trap handler leaves by trap return
    instr(OP_SOFT_TRAP, 8'h00, 3'h0);
    take(3'h0, 8'h00, 8'h00, TRAP_VEC_LO, 1'b0, 1'b0, 1'b0);
    instr(OP_RETURN_FROM_TRAP, 8'h86, 3'h0);
    check(o_status, 8'h86);
    $display("test soft_trap done");
    // Clear the return hold first, so only internal RAM execution stops the forced take
    instr(OP_NONE, 8'h00, 3'h0);
    @(posedge i_clk);
    i_ram_exec <= 1'b1;
    raise(8'h10);
    idle(30);
    instr(OP_NONE, 8'h00, 3'h0);
    take(3'h4, 8'h86, 8'h00, 20'h0000C, 1'b1, 1'b0, 1'b0);
    @(posedge i_clk);
    i_ram_exec <= 1'b0;
    $display("test ram_exec done");
    // Reset in mid-run must bring back the status word after reset
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    check(o_status, 8'h06);
    check(o_busy, 1'b0);
    $display("test mid_reset done");
    stop_test();
  end
endmodule
